/* design/flash_rewrite_sequencer.sv */
// flash rewrite sequencer: erase, download, program, verify and lock
// Behaviour
// RULE1 - unlock then erase every block before programming
// RULE2 - erase by block erase command, errors reset
// RULE3 - unlock each block before programming it
// RULE4 - program in 256-byte pages: fetch, program, verify
// RULE5 - lock bit programmed after block written
// RULE6 - program/lock errors reset unit, verify errors halt
// RULE7 - send request, store 256 received bytes
// RULE8 - tool sends full pages, pads with FF
// RULE9 - one program command per page
// RULE10 - clear entry bit, wait 1 us before verify
// RULE11 - compare 256 read bytes against buffer
// RULE12 - set entry bit again after verify
// RULE13 - lock program command; done after last block
// RULE14 - lock read command; zero means protected
// RULE15 - protected block unlocked, unprotected left alone
// RULE16 - program mode error: abort, reset unit, halt
// RULE17 - read mode error: abort and halt only
// RULE18 - unit reset held 100 us then released
// RULE19 - data request is one byte 22h
// RULE20 - page data frames standard id 111h, 8 bytes
// RULE21 - page program timeout 12 ms
// RULE22 - flash operation timeout handled as program error
// RULE23 - frame bytes stored in reception order
`timescale 1ns/1ps
`default_nettype none
module flash_rewrite_sequencer #(
  parameter int UNIT_RESET_CYC = flash_seq_pkg::UNIT_RESET_US *
                                 flash_seq_pkg::CLK_MHZ,
  parameter int PAGE_PROG_CYC = flash_seq_pkg::PAGE_PROG_MS * 1000 *
                                flash_seq_pkg::CLK_MHZ,
  parameter int ERASE_8K_CYC = flash_seq_pkg::ERASE_8K_MS * 1000 *
                               flash_seq_pkg::CLK_MHZ,
  parameter int ERASE_64K_CYC = flash_seq_pkg::ERASE_64K_MS * 1000 *
                                flash_seq_pkg::CLK_MHZ,
  parameter int ERASE_128K_CYC = flash_seq_pkg::ERASE_128K_MS * 1000 *
                                 flash_seq_pkg::CLK_MHZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output flash_seq_pkg::fcu_req_s fcu_req,
  input wire flash_seq_pkg::fcu_rsp_s fcu_rsp,
  input wire logic [7:0] fcu_buf_idx,
  output logic [7:0] fcu_buf_data,
  output logic pe_mode_entry_bit,
  output logic flash_unit_reset_bit,
  output logic flash_rd_en,
  output logic [19:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_data,
  output flash_seq_pkg::can_tx_s can_tx,
  input wire logic can_tx_ready,
  input wire flash_seq_pkg::can_frame_s can_rx
);
  typedef enum logic [13:0] {
    S_IDLE = 14'h0001, S_ENTER = 14'h0002, S_LOCK_READ = 14'h0004,
    S_LOCK_CLEAR = 14'h0008, S_ERASE = 14'h0010, S_REQ = 14'h0020,
    S_RECV = 14'h0040, S_PROG = 14'h0080, S_READ_MODE = 14'h0100,
    S_VERIFY = 14'h0200, S_PE_MODE = 14'h0400, S_LOCK_PROG = 14'h0800,
    S_UNIT_RESET = 14'h1000, S_HALT = 14'h2000
  } seq_state_e;

  seq_state_e st;
  logic writing;
  logic issued;
  logic done_flag;
  logic pe_err;
  logic rd_err;
  logic [31:0] tmr;
  logic [4:0] blk;
  logic [9:0] pg;
  logic [19:0] page_addr;
  logic [4:0] frame_cnt;
  logic [8:0] vfy_idx;
  logic vfy_cmp;
  logic [7:0] cmp_idx;
  logic [7:0] buf_rd_q;
  logic wr_pend;
  logic [7:0] wr_addr;

  // block geometry and command selection
  wire is_8k = blk < flash_seq_pkg::FIRST_64K_BLOCK;
  wire is_128k = blk >= flash_seq_pkg::FIRST_128K_BLOCK;
  wire [9:0] blk_pages = is_8k ? flash_seq_pkg::PAGES_8K :
                         is_128k ? flash_seq_pkg::PAGES_128K :
                         flash_seq_pkg::PAGES_64K;
  wire last_page = pg == blk_pages - 10'h001;
  wire last_block = blk == flash_seq_pkg::LAST_BLOCK;
  wire cmd_state = st == S_LOCK_READ || st == S_LOCK_CLEAR ||
                   st == S_ERASE || st == S_PROG || st == S_LOCK_PROG;
  wire [31:0] erase_lim = is_8k ? 32'(ERASE_8K_CYC) :
                          is_128k ? 32'(ERASE_128K_CYC) :
                          32'(ERASE_64K_CYC);
  wire [31:0] cmd_lim = st == S_ERASE ? erase_lim :
                        st == S_LOCK_READ || st == S_LOCK_CLEAR ?
                        32'(flash_seq_pkg::LOCK_READ_CYC) :
                        32'(PAGE_PROG_CYC); // [RULE21]
  wire flash_seq_pkg::fcu_cmd_e cmd_sel =
    st == S_ERASE ? flash_seq_pkg::CMD_ERASE :
    st == S_PROG ? flash_seq_pkg::CMD_PROGRAM :
    st == S_LOCK_READ ? flash_seq_pkg::CMD_LOCK_READ :
    st == S_LOCK_CLEAR ? flash_seq_pkg::CMD_LOCK_UNPROTECT :
    flash_seq_pkg::CMD_LOCK_PROGRAM;
  wire cmd_ok = issued && fcu_rsp.done && !fcu_rsp.error;
  wire cmd_fail = issued && ((fcu_rsp.done && fcu_rsp.error) ||
                  (!fcu_rsp.done && tmr == 32'h0000_0000));
  wire after_unlock_erase = !writing;
  wire rx_take = st == S_RECV && can_rx.valid &&
                 can_rx.id == flash_seq_pkg::DATA_ID &&
                 can_rx.dlc == flash_seq_pkg::DATA_DLC; // [RULE20]
  wire mismatch = vfy_cmp && flash_rd_data != buf_rd_q;

  // bus decode
  wire bus_go = hsel && hready && htrans[1];
  wire start_pulse = wr_pend && wr_addr == flash_seq_pkg::CTRL_OFS &&
                     hwdata[flash_seq_pkg::START_BIT];
  wire [31:0] status_word = {2'h0, st, 8'h00, issued, writing, rd_err,
                             pe_err, done_flag, pe_mode_entry_bit,
                             flash_unit_reset_bit, st != S_IDLE};
  wire [31:0] pos_word = {14'h0000, pg, 3'h0, blk};
  wire [7:0] rd_ofs = haddr[7:0];
  wire [31:0] rd_word = rd_ofs == flash_seq_pkg::STATUS_OFS ? status_word :
                        rd_ofs == flash_seq_pkg::POS_OFS ? pos_word :
                        rd_ofs == flash_seq_pkg::ADDR_OFS ?
                        {12'h000, page_addr} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= bus_go && hwrite;
      wr_addr <= haddr[7:0];
      if (bus_go && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // page buffer: one array per byte lane, row = frame number
  wire [7:0] rd_idx = st == S_VERIFY ? vfy_idx[7:0] : fcu_buf_idx;
  logic [7:0] lane_rd [flash_seq_pkg::LANES];
  genvar k;
  generate
    for (k = 0; k < flash_seq_pkg::LANES; k++) begin : g_lane
      logic [7:0] mem [flash_seq_pkg::ROWS];
      always_ff @(posedge hclk) begin
        if (rx_take) begin
          mem[frame_cnt] <= can_rx.data[8*k +: 8]; // [RULE7] [RULE23]
        end
      end
      assign lane_rd[k] = mem[rd_idx[7:3]];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_rd_q <= 8'h00;
    end else begin
      buf_rd_q <= lane_rd[rd_idx[2:0]];
    end
  end
  assign fcu_buf_data = buf_rd_q;

  // sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= S_IDLE;
      writing <= 1'b0;
      issued <= 1'b0;
      done_flag <= 1'b0;
      pe_err <= 1'b0;
      rd_err <= 1'b0;
      tmr <= 32'h0000_0000;
      blk <= flash_seq_pkg::FIRST_BLOCK;
      pg <= 10'h000;
      page_addr <= flash_seq_pkg::BASE_OFFSET;
      frame_cnt <= 5'h00;
      vfy_idx <= 9'h000;
      vfy_cmp <= 1'b0;
      cmp_idx <= 8'h00;
      fcu_req <= '0;
      pe_mode_entry_bit <= 1'b0;
      flash_unit_reset_bit <= 1'b0;
      flash_rd_en <= 1'b0;
      flash_rd_addr <= 20'h00000;
      can_tx <= '0;
    end else begin
      fcu_req.valid <= 1'b0;
      flash_rd_en <= 1'b0;
      vfy_cmp <= 1'b0;
      if (cmd_state && !issued) begin
        fcu_req.valid <= 1'b1; // [RULE9]
        fcu_req.cmd <= cmd_sel; // [RULE2] [RULE13] [RULE14]
        fcu_req.block <= blk;
        fcu_req.addr <= page_addr;
        issued <= 1'b1;
        tmr <= cmd_lim;
      end else if (cmd_state && cmd_fail) begin
        issued <= 1'b0;
        pe_err <= 1'b1; // [RULE2] [RULE6] [RULE22]
        flash_unit_reset_bit <= 1'b1; // [RULE16] [RULE18]
        tmr <= 32'(UNIT_RESET_CYC);
        st <= S_UNIT_RESET;
      end else if (cmd_state && issued && !cmd_ok) begin
        tmr <= tmr - 32'h0000_0001;
      end else begin
        if (cmd_state) begin
          issued <= 1'b0;
        end
        case (st)
          S_IDLE: begin
            if (start_pulse) begin
              pe_mode_entry_bit <= 1'b1;
              tmr <= 32'(flash_seq_pkg::MODE_WAIT_CYC);
              blk <= flash_seq_pkg::FIRST_BLOCK;
              pg <= 10'h000;
              page_addr <= flash_seq_pkg::BASE_OFFSET;
              writing <= 1'b0;
              done_flag <= 1'b0;
              st <= S_ENTER;
            end
          end
          S_ENTER, S_READ_MODE, S_PE_MODE: begin
            if (tmr != 32'h0000_0000) begin
              tmr <= tmr - 32'h0000_0001;
            end else if (st == S_ENTER) begin
              st <= S_LOCK_READ;
            end else if (st == S_READ_MODE) begin
              vfy_idx <= 9'h000;
              st <= S_VERIFY;
            end else if (last_page) begin
              page_addr <= page_addr + flash_seq_pkg::PAGE_STEP;
              st <= S_LOCK_PROG; // [RULE5]
            end else begin
              page_addr <= page_addr + flash_seq_pkg::PAGE_STEP;
              pg <= pg + 10'h001;
              st <= S_REQ; // [RULE4]
            end
          end
          S_LOCK_READ: begin
            if (!fcu_rsp.lock_status) begin
              st <= S_LOCK_CLEAR; // [RULE15]
            end else begin
              st <= after_unlock_erase ? S_ERASE : S_REQ; // [RULE1] [RULE3]
            end
          end
          S_LOCK_CLEAR: begin
            st <= after_unlock_erase ? S_ERASE : S_REQ; // [RULE1] [RULE3]
          end
          S_ERASE: begin
            if (last_block) begin
              blk <= flash_seq_pkg::FIRST_BLOCK;
              writing <= 1'b1; // [RULE1]
            end else begin
              blk <= blk + 5'h01;
            end
            st <= S_LOCK_READ;
          end
          S_REQ: begin
            can_tx.valid <= 1'b1;
            can_tx.id <= flash_seq_pkg::REQ_ID;
            can_tx.data <= flash_seq_pkg::REQ_CMD; // [RULE19]
            if (can_tx.valid && can_tx_ready) begin
              can_tx.valid <= 1'b0;
              frame_cnt <= 5'h00;
              st <= S_RECV; // [RULE7]
            end
          end
          S_RECV: begin
            if (rx_take) begin
              frame_cnt <= frame_cnt + 5'h01;
              if (frame_cnt == flash_seq_pkg::LAST_FRAME) begin
                st <= S_PROG;
              end
            end
          end
          S_PROG: begin
            pe_mode_entry_bit <= 1'b0; // [RULE10]
            tmr <= 32'(flash_seq_pkg::MODE_WAIT_CYC);
            st <= S_READ_MODE;
          end
          S_VERIFY: begin
            if (!vfy_idx[8]) begin
              flash_rd_en <= 1'b1;
              flash_rd_addr <= page_addr + 20'(vfy_idx[7:0]);
              vfy_idx <= vfy_idx + 9'h001;
              vfy_cmp <= 1'b1;
              cmp_idx <= vfy_idx[7:0];
            end
            if (mismatch) begin
              rd_err <= 1'b1; // [RULE11] [RULE6] [RULE17]
              vfy_cmp <= 1'b0;
              flash_rd_en <= 1'b0;
              st <= S_HALT;
            end else if (vfy_cmp && cmp_idx == flash_seq_pkg::LAST_BYTE) begin
              pe_mode_entry_bit <= 1'b1; // [RULE12]
              tmr <= 32'(flash_seq_pkg::MODE_WAIT_CYC);
              st <= S_PE_MODE;
            end
          end
          S_LOCK_PROG: begin
            if (last_block) begin
              done_flag <= 1'b1; // [RULE13]
              pe_mode_entry_bit <= 1'b0;
              st <= S_HALT;
            end else begin
              blk <= blk + 5'h01;
              pg <= 10'h000;
              st <= S_LOCK_READ; // [RULE3]
            end
          end
          S_UNIT_RESET: begin
            if (tmr != 32'h0000_0000) begin
              tmr <= tmr - 32'h0000_0001;
            end else begin
              flash_unit_reset_bit <= 1'b0; // [RULE18]
              st <= S_HALT; // [RULE16]
            end
          end
          default: begin
            st <= S_HALT;
          end
        endcase
      end
    end
  end

  // checks
  a_req_content: assert property (@(posedge hclk) disable iff (!hresetn)
    can_tx.valid |-> can_tx.data == flash_seq_pkg::REQ_CMD &&
      can_tx.id == flash_seq_pkg::REQ_ID)
    else $error("bad request frame"); // [RULE19]
  a_verify_read_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_rd_en |-> !pe_mode_entry_bit && st == S_VERIFY)
    else $error("verify read outside read mode"); // [RULE10]
  a_mode_wait_held: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(pe_mode_entry_bit) && st == S_READ_MODE |-> !flash_rd_en [*8])
    else $error("read started before mode wait"); // [RULE10]
  a_program_after_erase: assert property (@(posedge hclk)
    disable iff (!hresetn)
    fcu_req.valid && fcu_req.cmd == flash_seq_pkg::CMD_PROGRAM |-> writing)
    else $error("program before erase finished"); // [RULE1]
  a_cmd_one_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    fcu_req.valid |=> !fcu_req.valid)
    else $error("command strobe longer than one cycle"); // [RULE9]
  a_lock_on_last_page: assert property (@(posedge hclk)
    disable iff (!hresetn)
    fcu_req.valid && fcu_req.cmd == flash_seq_pkg::CMD_LOCK_PROGRAM
      |-> writing && last_page)
    else $error("lock bit programmed early"); // [RULE5]
  a_reset_release: assert property (@(posedge hclk) disable iff (!hresetn)
    st == S_UNIT_RESET && tmr == 32'h0000_0000
      |=> st == S_HALT && !flash_unit_reset_bit)
    else $error("unit reset not released into halt"); // [RULE16] [RULE18]
  a_read_err_no_reset: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $rose(rd_err) |-> !flash_unit_reset_bit ##1 st == S_HALT)
    else $error("read mode error reset the unit"); // [RULE17]
  a_timeout_error: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_state && issued && !fcu_rsp.done && tmr == 32'h0000_0000
      |=> st == S_UNIT_RESET && flash_unit_reset_bit)
    else $error("timeout not handled"); // [RULE22]
  a_page_received: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_take && frame_cnt == flash_seq_pkg::LAST_FRAME |=> st == S_PROG)
    else $error("page complete but not programmed"); // [RULE7] [RULE4]
endmodule : flash_rewrite_sequencer
`default_nettype wire

/* design/flash_seq_pkg.sv */
// shared constants, types and register map of the flash rewrite sequencer
package flash_seq_pkg;
  localparam int CLK_MHZ = 250;
  // times in their own units
  localparam int MODE_WAIT_NS = 1000;
  localparam int LOCK_READ_US = 10;
  localparam int UNIT_RESET_US = 100;
  localparam int PAGE_PROG_MS = 12;
  localparam int ERASE_8K_MS = 150;
  localparam int ERASE_64K_MS = 1120;
  localparam int ERASE_128K_MS = 2240;
  // short counts, rounded up to whole cycles
  localparam int MODE_WAIT_CYC = (MODE_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_READ_CYC = LOCK_READ_US * CLK_MHZ;
  // block range and geometry
  localparam logic [4:0] FIRST_BLOCK = 5'h02;
  localparam logic [4:0] LAST_BLOCK = 5'h13;
  localparam logic [4:0] FIRST_64K_BLOCK = 5'h08;
  localparam logic [4:0] FIRST_128K_BLOCK = 5'h11;
  localparam logic [9:0] PAGES_8K = 10'h020;
  localparam logic [9:0] PAGES_64K = 10'h100;
  localparam logic [9:0] PAGES_128K = 10'h200;
  localparam logic [19:0] BASE_OFFSET = 20'h04000;
  localparam logic [19:0] PAGE_STEP = 20'h00100;
  localparam logic [7:0] LAST_BYTE = 8'hFF;
  localparam int LANES = 8;
  localparam int ROWS = 32;
  localparam logic [4:0] LAST_FRAME = 5'h1F;
  // link constants
  localparam logic [7:0] REQ_CMD = 8'h22;
  localparam logic [10:0] REQ_ID = 11'h101;
  localparam logic [10:0] DATA_ID = 11'h111;
  localparam logic [3:0] DATA_DLC = 4'h8;
  // register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] POS_OFS = 8'h08;
  localparam logic [7:0] ADDR_OFS = 8'h0C;
  localparam int START_BIT = 0;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_ERASE = 3'h1, CMD_PROGRAM = 3'h2,
    CMD_LOCK_READ = 3'h3, CMD_LOCK_UNPROTECT = 3'h4, CMD_LOCK_PROGRAM = 3'h5
  } fcu_cmd_e;

  typedef struct packed {
    logic valid;
    fcu_cmd_e cmd;
    logic [4:0] block;
    logic [19:0] addr;
  } fcu_req_s;

  typedef struct packed {
    logic done;
    logic error;
    logic lock_status;
  } fcu_rsp_s;

  typedef struct packed {
    logic valid;
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } can_frame_s;

  typedef struct packed {
    logic valid;
    logic [10:0] id;
    logic [7:0] data;
  } can_tx_s;
endpackage : flash_seq_pkg

/* test/flash_unit_model.sv */
// behavioural flash unit, flash array and rewrite tool at the far side
`timescale 1ns/1ps
`default_nettype none
module flash_unit_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire flash_seq_pkg::fcu_req_s fcu_req,
  output flash_seq_pkg::fcu_rsp_s fcu_rsp,
  output logic [7:0] fcu_buf_idx,
  input wire logic [7:0] fcu_buf_data,
  input wire logic flash_rd_en,
  input wire logic [19:0] flash_rd_addr,
  output logic [7:0] flash_rd_data,
  input wire flash_seq_pkg::can_tx_s can_tx,
  output logic can_tx_ready,
  output flash_seq_pkg::can_frame_s can_rx,
  input wire flash_seq_pkg::fcu_cmd_e err_cmd,
  input wire flash_seq_pkg::fcu_cmd_e hang_cmd,
  input wire logic bad_read,
  input wire logic slow
);
  logic [7:0] mem [256];
  logic [19:0] open_blk;
  logic [7:0] page;
  logic [63:0] d;
  flash_seq_pkg::fcu_req_s r;
  logic [7:0] idle_rd;
  initial begin
    fcu_rsp = '0;
    fcu_buf_idx = 8'h00;
    idle_rd = 8'h00;
    can_tx_ready = 1'b0;
    can_rx = '0;
  end
  // even blocks start protected, odd ones open
  always @(negedge hresetn) begin
    open_blk = 20'hAAAAA;
    page = 8'h00;
  end
  // flash unit: answers each command except hang_cmd, programs by fetching the page buffer
  always begin : fcu_side
    @(posedge hclk);
    if (fcu_req.valid === 1'b1) begin
      r = fcu_req;
      repeat (slow ? 30 : 2) @(posedge hclk);
      if (r.cmd !== hang_cmd) begin
        if (r.cmd == flash_seq_pkg::CMD_PROGRAM) begin
          for (int i = 0; i <= 256; i++) begin
            fcu_buf_idx <= i[7:0];
            @(posedge hclk);
            if (i > 0)
              mem[i - 1] = fcu_buf_data;
          end
        end
        if (r.cmd == flash_seq_pkg::CMD_LOCK_UNPROTECT)
          open_blk[r.block] = 1'b1;
        if (r.cmd == flash_seq_pkg::CMD_LOCK_PROGRAM)
          open_blk[r.block] = 1'b0;
        fcu_rsp <= '{1'b1, r.cmd == err_cmd, open_blk[r.block]};
        @(posedge hclk);
        fcu_rsp <= '0;
      end
    end
  end
  // flash array read port answers in the read cycle, idle data inverts
  always @(posedge hclk)
    idle_rd <= ~idle_rd;
  assign flash_rd_data = flash_rd_en ? mem[flash_rd_addr[7:0]] ^
                         {7'h00, bad_read} : idle_rd;
  // rewrite tool: one page of frames per accepted request
  always begin : tool_side
    @(posedge hclk);
    if (can_tx.valid === 1'b1) begin
      repeat (slow ? 6 : 0) @(posedge hclk);
      can_tx_ready <= 1'b1;
      @(posedge hclk);
      can_tx_ready <= 1'b0;
      can_rx <= '{1'b1, 11'h100, 4'h8, ~64'h0};
      for (int f = 0; f < 32; f++) begin
        @(posedge hclk);
        can_rx.valid <= 1'b0;
        can_rx.data <= ~can_rx.data;
        for (int j = 0; j < 8; j++)
          d[8 * j +: 8] = (f > 29) ? 8'hFF : page + 8'(8 * f + j);
        @(posedge hclk);
        can_rx <= '{1'b1, flash_seq_pkg::DATA_ID, flash_seq_pkg::DATA_DLC, d};
      end
      @(posedge hclk);
      can_rx.valid <= 1'b0;
      page = page + 8'h01;
    end
  end
endmodule : flash_unit_model
`default_nettype wire

/* test/flash_rewrite_sequencer_tb.sv */
// testbench of the flash rewrite sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_rewrite_sequencer_tb;
  localparam int URST = 20;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, s;
  flash_seq_pkg::fcu_req_s fcu_req;
  flash_seq_pkg::fcu_rsp_s fcu_rsp;
  flash_seq_pkg::can_tx_s can_tx;
  flash_seq_pkg::can_frame_s can_rx;
  flash_seq_pkg::fcu_cmd_e err_cmd, hang_cmd;
  logic [7:0] buf_idx, buf_data, rd_data;
  logic [19:0] rd_addr;
  logic pe, urst, rd_en, tx_ready, bad_read, slow;
  logic [7:0] seq[$], exp_q[$];
  int err_total, samples_checked, cyc, pages, rd_idx, lk3, reqs, ro_cyc;
  int urst_cyc;

  flash_rewrite_sequencer #(.UNIT_RESET_CYC(URST), .PAGE_PROG_CYC(1000),
    .ERASE_8K_CYC(300), .ERASE_64K_CYC(400), .ERASE_128K_CYC(500)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp),
    .fcu_req(fcu_req), .fcu_rsp(fcu_rsp), .fcu_buf_idx(buf_idx),
    .fcu_buf_data(buf_data), .pe_mode_entry_bit(pe),
    .flash_unit_reset_bit(urst), .flash_rd_en(rd_en),
    .flash_rd_addr(rd_addr), .flash_rd_data(rd_data), .can_tx(can_tx),
    .can_tx_ready(tx_ready), .can_rx(can_rx));

  flash_unit_model model_u (.hclk(hclk), .hresetn(hresetn),
    .fcu_req(fcu_req), .fcu_rsp(fcu_rsp), .fcu_buf_idx(buf_idx),
    .fcu_buf_data(buf_data), .flash_rd_en(rd_en), .flash_rd_addr(rd_addr),
    .flash_rd_data(rd_data), .can_tx(can_tx), .can_tx_ready(tx_ready),
    .can_rx(can_rx), .err_cmd(err_cmd), .hang_cmd(hang_cmd),
    .bad_read(bad_read), .slow(slow));

  task automatic compare(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : compare

  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rd_chk(input string nm, input logic [31:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    compare(nm, e, v & m);
    compare("hresp", 0, hresp);
  endtask : rd_chk

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    seq.delete();
    pages = 0;
    lk3 = 0;
    reqs = 0;
    urst_cyc = 0;
    hresetn <= 1'b1;
    @(posedge hclk);
    compare("rst_outs", 0, {urst, pe, rd_en, can_tx.valid, fcu_req.valid});
  endtask : do_reset

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // cycle ceiling: a hang counts as a mismatch
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      wrap_up();
    end
  end

  // watches the flash and link sides of every run
  always @(posedge hclk) begin
    if (fcu_req.valid === 1'b1) begin
      seq.push_back({fcu_req.cmd, fcu_req.block});
      compare("pe_mode", 1, pe);
      if (fcu_req.block == 5'h03 && fcu_req.cmd == 3'h3)
        lk3++;
      if (fcu_req.cmd == flash_seq_pkg::CMD_PROGRAM) begin
        compare("page_addr", 32'h4000 + pages * 256, 32'(fcu_req.addr));
        pages++;
        rd_idx = 0;
      end
    end
    if (fcu_rsp.done === 1'b1 && fcu_req.cmd == flash_seq_pkg::CMD_PROGRAM)
      for (int k = 0; k < 256; k++)
        compare("page_byte", k > 239 ? 8'hFF : 8'(pages - 1 + k), model_u.mem[k]);
    if (rd_en === 1'b1) begin
      compare("rd_addr", 32'h4000 + (pages - 1) * 256 + rd_idx, 32'(rd_addr));
      compare("rd_mode", 0, pe);
      if (rd_idx == 0)
        compare("mode_wait", 1, 32'(ro_cyc >= flash_seq_pkg::MODE_WAIT_CYC));
      rd_idx++;
    end
    if (can_tx.valid === 1'b1 && tx_ready === 1'b1) begin
      compare("req_frame", {21'h101, 8'h22}, {can_tx.id, can_tx.data});
      reqs++;
    end
    ro_cyc = pe ? 0 : ro_cyc + 1;
    if (urst === 1'b1)
      urst_cyc++;
  end

  initial begin
    hresetn = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_cmd = flash_seq_pkg::CMD_NONE;
    hang_cmd = flash_seq_pkg::CMD_NONE;
    bad_read = 1'b0;
    slow = 1'b0;
    do_reset();
    rd_chk("status_rst", 32'h04, 32'hFFFFFFFF, 32'h00010000);
    rd_chk("ctrl_rd", 32'h00, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, 32'h40, 32'hFFFFFFFF, s);
    rd_chk("unmapped", 32'h40, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, 32'h00, 32'h1, s);
    rd_chk("busy", 32'h04, 32'h1, 32'h1);
    wait (lk3 == 2);
    for (int b = 2; b < 20; b++) begin
      exp_q.push_back({3'h3, b[4:0]});
      if (!b[0])
        exp_q.push_back({3'h4, b[4:0]});
      exp_q.push_back({3'h1, b[4:0]});
    end
    exp_q.push_back({3'h3, 5'h02});
    repeat (32) exp_q.push_back({3'h2, 5'h02});
    exp_q.push_back({3'h5, 5'h02});
    exp_q.push_back({3'h3, 5'h03});
    compare("seq_len", exp_q.size(), seq.size());
    foreach (exp_q[i]) compare("fcu_seq", exp_q[i], seq[i]);
    compare("req_cnt", 32, reqs);
    // error runs: lock read, erase, program errors, two hangs, bad verify
    for (int t = 0; t < 6; t++) begin
      err_cmd <= flash_seq_pkg::fcu_cmd_e'(t == 0 ? 3 : (t < 3 ? t : 0));
      hang_cmd <= flash_seq_pkg::fcu_cmd_e'(t == 3 || t == 4 ? t - 2 : 0);
      bad_read <= (t == 5);
      slow <= 1'b1;
      do_reset();
      ahb(1'b1, 32'h00, 32'h1, s);
      do ahb(1'b0, 32'h04, 32'h0, s); while (s[29] !== 1'b1);
      compare("halt_bits", t == 5 ? 32'h20 : 32'h10, s & 32'h32);
      compare("unit_rst", t == 5 ? 0 : URST + 1, urst_cyc);
    end
    wrap_up();
  end
endmodule : flash_rewrite_sequencer_tb
`default_nettype wire
